// >>> pdc_top.sv
// Register file, post dividers and output crosspoint of the PLL clock generator
`timescale 1ns/10ps
module pdc_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Clock ticks, one cycle each
	input wire logic vco_tick,
	input wire logic ref_tick,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// PLL settings
	output pdc_pkg::pdc_pll_cfg_t pll_cfg,
	// Clock pins
	output logic first_output_pin,
	output logic second_output_pin_o,
	output logic second_output_pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] oe_r;
	pdc_pkg::pdc_bank_cfg_t bank_cfg_r [2];
	logic [4:0] pfh_r;
	logic [7:0] fbl_r;
	logic [7:0] odp_r;
	logic [5:0] oss_r;
	logic [7:0] rdata_nxt;

	function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
			input logic [7:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	// Output enables, only the two enable bits hold a one
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oe_r <= pdc_pkg::RST_OE;
		end else if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_OE)) begin
			oe_r <= '0;
			oe_r[pdc_pkg::OE_FIRST_BIT] <= reg_wdata[pdc_pkg::OE_FIRST_BIT];
			oe_r[pdc_pkg::OE_SECOND_BIT] <= reg_wdata[pdc_pkg::OE_SECOND_BIT];
		end
	end

	// Bank sources and divisors
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bank_cfg_r[0] <= pdc_pkg::RST_BANK;
			bank_cfg_r[1] <= pdc_pkg::RST_BANK;
		end else begin
			if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_B1)) begin
				bank_cfg_r[0] <= reg_wdata;
			end
			if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_B2)) begin
				bank_cfg_r[1] <= reg_wdata;
			end
		end
	end

	// Pump code and upper feedback bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pfh_r <= pdc_pkg::RST_PFH;
		end else if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_PFH)) begin
			pfh_r <= reg_wdata[4:0] & pdc_pkg::PFH_WMASK;
		end
	end

	// Lower feedback bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fbl_r <= pdc_pkg::RST_FBL;
		end else if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_FBL)) begin
			fbl_r <= reg_wdata;
		end
	end

	// Odd bit and predivider
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			odp_r <= pdc_pkg::RST_ODP;
		end else if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_ODP)) begin
			odp_r <= reg_wdata;
		end
	end

	// Output source codes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oss_r <= pdc_pkg::RST_OSS;
		end else if (wr_hit(reg_wr, reg_addr, pdc_pkg::ADDR_OSS)) begin
			oss_r <= reg_wdata[6:1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read back
	always_comb begin
		case (reg_addr)
			pdc_pkg::ADDR_OE: rdata_nxt = oe_r;
			pdc_pkg::ADDR_B1: rdata_nxt = bank_cfg_r[0];
			pdc_pkg::ADDR_B2: rdata_nxt = bank_cfg_r[1];
			pdc_pkg::ADDR_PFH: rdata_nxt = {pdc_pkg::PFH_FIXED, pfh_r};
			pdc_pkg::ADDR_FBL: rdata_nxt = fbl_r;
			pdc_pkg::ADDR_ODP: rdata_nxt = odp_r;
			pdc_pkg::ADDR_OSS: rdata_nxt = {1'b1, oss_r, 1'b1};
			default: rdata_nxt = pdc_pkg::RD_NONE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= pdc_pkg::RD_NONE;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PLL arithmetic
	logic [9:0] feedback_base_value;
	logic feedback_odd_bit;
	logic [11:0] mult_nxt;
	logic [7:0] prediv_nxt;

	assign feedback_base_value = {pfh_r[1:0], fbl_r};
	assign feedback_odd_bit = odp_r[pdc_pkg::ODD_BIT];
	// Range 8 to 2055 fits in twelve bits
	assign mult_nxt = 12'(({2'b00, feedback_base_value} + pdc_pkg::FB_OFFSET) << 1)
		+ {11'h000, feedback_odd_bit};
	assign prediv_nxt = {1'b0, odp_r[6:0]} + pdc_pkg::PREDIV_OFFSET;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pll_cfg <= '0;
		end else begin
			pll_cfg.total_mult <= mult_nxt;
			pll_cfg.total_prediv <= prediv_nxt;
			pll_cfg.pump_code <= pfh_r[pdc_pkg::PUMP_LSB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider banks
	logic [1:0] bank_tick;
	logic [6:0] cnt_r [2];
	logic [6:0] n_act_r [2];
	logic [1:0] c3_r [2];
	pdc_pkg::pdc_bank_out_t bank_out_r [2];
	logic [1:0] bank_wrap;

	function automatic logic [6:0] run_div(input logic [6:0] d);
		run_div = (d < pdc_pkg::DIV_MIN_RUN) ? pdc_pkg::DIV_MIN_RUN : d;
	endfunction

	always_comb begin
		for (int b = 0; b < 2; b++) begin
			bank_tick[b] = bank_cfg_r[b].use_ref ? ref_tick : vco_tick;
			bank_wrap[b] = bank_tick[b] && (cnt_r[b] >= n_act_r[b] - 7'h01);
		end
	end

	// Tick counters
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int b = 0; b < 2; b++) begin
				cnt_r[b] <= '0;
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (bank_wrap[b]) begin
					cnt_r[b] <= '0;
				end else if (bank_tick[b]) begin
					cnt_r[b] <= cnt_r[b] + 7'h01;
				end
			end
		end
	end

	// New divisor only at wrap, so no runt cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int b = 0; b < 2; b++) begin
				n_act_r[b] <= pdc_pkg::RST_BANK[6:0];
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (bank_wrap[b]) begin
					n_act_r[b] <= run_div(bank_cfg_r[b].divisor);
				end
			end
		end
	end

	// Modulo three count restarted at wrap
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int b = 0; b < 2; b++) begin
				c3_r[b] <= '0;
			end
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (bank_wrap[b]) begin
					c3_r[b] <= '0;
				end else if (bank_tick[b]) begin
					c3_r[b] <= (c3_r[b] == 2'h2) ? 2'h0 : c3_r[b] + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bank_out_r[0] <= '0;
			bank_out_r[1] <= '0;
		end else begin
			for (int b = 0; b < 2; b++) begin
				// All fixed outputs restart high at the divisor wrap
				bank_out_r[b].div_out <= cnt_r[b] < (n_act_r[b] >> 1);
				bank_out_r[b].half_out <= ~cnt_r[b][0];
				bank_out_r[b].third_out <= c3_r[b] == 2'h0;
				bank_out_r[b].quarter_out <= ~cnt_r[b][1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output crosspoint
	logic ref_level_r;
	logic [2:0] sel_act_r [2];
	logic [1:0] pin_r;
	logic [1:0] en_act_r;
	logic [2:0] sel_req [2];
	logic [1:0] en_req;

	function automatic logic src_level(input logic [2:0] code, input logic rlev,
			input pdc_pkg::pdc_bank_out_t o1, input pdc_pkg::pdc_bank_out_t o2);
		case (pdc_pkg::pdc_src_t'(code))
			pdc_pkg::PDC_SRC_REF: src_level = rlev;
			pdc_pkg::PDC_SRC_B1_DIV: src_level = o1.div_out;
			pdc_pkg::PDC_SRC_B1_HALF: src_level = o1.half_out;
			pdc_pkg::PDC_SRC_B1_THIRD: src_level = o1.third_out;
			pdc_pkg::PDC_SRC_B2_DIV: src_level = o2.div_out;
			pdc_pkg::PDC_SRC_B2_HALF: src_level = o2.half_out;
			pdc_pkg::PDC_SRC_B2_QUARTER: src_level = o2.quarter_out;
			default: src_level = 1'b0;
		endcase
	endfunction

	assign sel_req[0] = oss_r[pdc_pkg::SRC1_LSB - 1 +: 3];
	assign sel_req[1] = oss_r[pdc_pkg::SRC2_LSB - 1 +: 3];
	assign en_req[0] = oe_r[pdc_pkg::OE_FIRST_BIT];
	// Second pin is an output only when enabled with a real source
	assign en_req[1] = oe_r[pdc_pkg::OE_SECOND_BIT]
		&& (sel_req[1] != pdc_pkg::PDC_SRC_RESERVED);

	// Reference shown as half the tick rate
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_level_r <= 1'b0;
		end else if (ref_tick) begin
			ref_level_r <= ~ref_level_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sel_act_r[0] <= pdc_pkg::PDC_SRC_REF;
			sel_act_r[1] <= pdc_pkg::PDC_SRC_RESERVED;
			en_act_r <= '0;
			pin_r <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				// Switch only while pin and new source are both low
				if (!pin_r[p] && !src_level(sel_req[p], ref_level_r,
						bank_out_r[0], bank_out_r[1])) begin
					sel_act_r[p] <= sel_req[p];
					en_act_r[p] <= en_req[p];
				end else if (!en_req[p] && !src_level(sel_act_r[p], ref_level_r,
						bank_out_r[0], bank_out_r[1])) begin
					en_act_r[p] <= 1'b0;
				end
				// Disabled output rests low, falling only from high normally
				if (en_act_r[p] || pin_r[p]) begin
					pin_r[p] <= en_act_r[p] && src_level(sel_act_r[p], ref_level_r,
						bank_out_r[0], bank_out_r[1]);
				end else begin
					pin_r[p] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			first_output_pin <= 1'b0;
			second_output_pin_o <= 1'b0;
			second_output_pin_oe <= 1'b0;
		end else begin
			first_output_pin <= pin_r[0];
			second_output_pin_o <= pin_r[1] && en_req[1];
			second_output_pin_oe <= en_req[1];
		end
	end

endmodule // pdc_top

// >>> pdc_pkg.sv
// Constants, types and register map for the PLL divider and output configuration block
package pdc_pkg;
	localparam logic [7:0] ADDR_OE = 8'h09;
	localparam logic [7:0] ADDR_B1 = 8'h0C;
	localparam logic [7:0] ADDR_PFH = 8'h40;
	localparam logic [7:0] ADDR_FBL = 8'h41;
	localparam logic [7:0] ADDR_ODP = 8'h42;
	localparam logic [7:0] ADDR_OSS = 8'h45;
	localparam logic [7:0] ADDR_B2 = 8'h47;
	localparam logic [2:0] PFH_FIXED = 3'h6;
	localparam int PFH_FIXED_LSB = 5;
	localparam logic [4:0] PFH_WMASK = 5'h1F;
	localparam int PUMP_LSB = 2;
	localparam int OE_FIRST_BIT = 3;
	localparam int OE_SECOND_BIT = 4;
	localparam int SRC_BIT = 7;
	localparam int ODD_BIT = 7;
	localparam int SRC1_LSB = 4;
	localparam int SRC2_LSB = 1;
	localparam logic [11:0] FB_OFFSET = 12'h004;
	localparam logic [7:0] PREDIV_OFFSET = 8'h02;
	localparam logic [6:0] DIV_MIN_RUN = 7'h02;
	localparam logic [7:0] RST_OE = 8'h08;
	localparam logic [7:0] RST_BANK = 8'h08;
	localparam logic [4:0] RST_PFH = 5'h00;
	localparam logic [7:0] RST_FBL = 8'h00;
	localparam logic [7:0] RST_ODP = 8'h00;
	localparam logic [5:0] RST_OSS = 6'h07;
	localparam logic [7:0] RD_NONE = 8'h00;

	typedef enum logic [2:0] {
		PDC_SRC_REF = 3'b000,
		PDC_SRC_B1_DIV = 3'b001,
		PDC_SRC_B1_HALF = 3'b010,
		PDC_SRC_B1_THIRD = 3'b011,
		PDC_SRC_B2_DIV = 3'b100,
		PDC_SRC_B2_HALF = 3'b101,
		PDC_SRC_B2_QUARTER = 3'b110,
		PDC_SRC_RESERVED = 3'b111
	} pdc_src_t;

	typedef struct packed {
		logic use_ref;
		logic [6:0] divisor;
	} pdc_bank_cfg_t;

	typedef struct packed {
		logic div_out;
		logic half_out;
		logic third_out;
		logic quarter_out;
	} pdc_bank_out_t;

	typedef struct packed {
		logic [11:0] total_mult;
		logic [7:0] total_prediv;
		logic [2:0] pump_code;
	} pdc_pll_cfg_t;
endpackage

// >>> pdc_tick_src.sv
// Tick source standing in for the VCO and the reference oscillator
`timescale 1ns/10ps
module pdc_tick_src #(
	parameter int REF_P = 5
) (
	// Clock
	input wire logic clk_sys,
	// Ticks
	output logic vco_tick,
	output logic ref_tick
);
	int k = 0;
	initial begin
		vco_tick = 1'b1;
		ref_tick = 1'b0;
	end
	always @(posedge clk_sys) begin
		#1;
		k = (k + 1) % REF_P;
		ref_tick = (k == 0);
	end
endmodule // pdc_tick_src

// >>> pdc_top_asserts.sv
// Port checks for the divider and output configuration block
`timescale 1ns/10ps
module pdc_top_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Ticks and register port
	input wire logic vco_tick,
	input wire logic ref_tick,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Outputs
	input wire pdc_pkg::pdc_pll_cfg_t pll_cfg,
	input wire logic first_output_pin,
	input wire logic second_output_pin_o,
	input wire logic second_output_pin_oe
);
	logic [7:0] oe_r, b1_r, pfh_r, fbl_r, odp_r, oss_r, b2_r;
	logic [1:0] up_r;
	logic [9:0] off1_r, off2_r, on1_r;
	logic [11:0] mult_w;
	logic [7:0] exp_w;
	assign mult_w = (({2'h0, pfh_r[1:0], fbl_r} + 12'h004) << 1) + {11'h000, odp_r[7]};
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h09: return oe_r;
			8'h0C: return b1_r;
			8'h40: return pfh_r;
			8'h41: return fbl_r;
			8'h42: return odp_r;
			8'h45: return oss_r;
			8'h47: return b2_r;
			default: return 8'h00;
		endcase
	endfunction
	always_comb begin
		exp_w = exp_rd(reg_addr);
	end
	////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			oe_r <= 8'h08;
			b1_r <= 8'h08;
			pfh_r <= 8'hC0;
			fbl_r <= 8'h00;
			odp_r <= 8'h00;
			oss_r <= 8'h8F;
			b2_r <= 8'h08;
		end else if (reg_wr) begin
			case (reg_addr)
				8'h09: oe_r <= reg_wdata & 8'h18;
				8'h0C: b1_r <= reg_wdata;
				8'h40: pfh_r <= {3'h6, reg_wdata[4:0]};
				8'h41: fbl_r <= reg_wdata;
				8'h42: odp_r <= reg_wdata;
				8'h45: oss_r <= reg_wdata | 8'h81;
				8'h47: b2_r <= reg_wdata;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			up_r <= 2'h0;
			off1_r <= 10'h000;
			off2_r <= 10'h000;
			on1_r <= 10'h000;
		end else begin
			up_r <= (up_r == 2'h2) ? up_r : up_r + 2'h1;
			off1_r <= oe_r[3] ? 10'h000 : off1_r + {9'h0, off1_r != 10'h3FF};
			off2_r <= (oe_r[4] && oss_r[3:1] != 3'h7) ? 10'h000 : off2_r + {9'h0, off2_r != 10'h3FF};
			on1_r <= (oe_r[3] && oss_r[6:4] == 3'h0) ? on1_r + {9'h0, on1_r != 10'h3FF} : 10'h000;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || up_r != 2'h2);
	a_read_back: assert property (reg_rdata == $past(exp_w))
		else $error("read data differs from shadow");
	a_mult_calc: assert property (pll_cfg.total_mult == $past(mult_w))
		else $error("total multiplier wrong");
	a_prediv_calc: assert property (pll_cfg.total_prediv == $past({1'b0, odp_r[6:0]} + 8'h02))
		else $error("total predivision wrong");
	a_pump_field: assert property (pll_cfg.pump_code == $past(pfh_r[4:2]))
		else $error("pump code wrong");
	a_first_off: assert property (off1_r == 10'h3FF |-> !first_output_pin)
		else $error("disabled first pin not low");
	a_second_off: assert property (off2_r == 10'h3FF |-> !second_output_pin_oe)
		else $error("second pin driven while off");
	a_idle_low: assert property (!second_output_pin_oe |-> !second_output_pin_o)
		else $error("undriven second pin not low");
	a_ref_follow: assert property (($changed(first_output_pin) && on1_r == 10'h3FF) |->
		($past(ref_tick) || $past(ref_tick, 2) || $past(ref_tick, 3) || $past(ref_tick, 4)))
		else $error("reference pin moved without tick");
	c_full_mult: cover property (pll_cfg.total_mult == 12'h807);
	c_second_on: cover property (second_output_pin_oe && second_output_pin_o);
	c_unmapped: cover property ($past(reg_addr) == 8'h46);
endmodule // pdc_top_asserts

bind pdc_top pdc_top_asserts pdc_top_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
	.vco_tick(vco_tick), .ref_tick(ref_tick), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_cfg(pll_cfg),
	.first_output_pin(first_output_pin), .second_output_pin_o(second_output_pin_o),
	.second_output_pin_oe(second_output_pin_oe));

// >>> pdc_top_tb.sv
// Self-checking testbench for the divider and output configuration block
`timescale 1ns/10ps
module pdc_top_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic vco_tick, ref_tick, first_output_pin, second_output_pin_o, second_output_pin_oe;
	logic [7:0] reg_rdata, a, d;
	pdc_pkg::pdc_pll_cfg_t pll_cfg;
	logic [7:0] sh [256];
	logic [7:0] adr [10] = '{8'h09, 8'h0C, 8'h40, 8'h41, 8'h42, 8'h45, 8'h47, 8'h00, 8'h46, 8'hFF};
	logic [7:0] b1 [8] = '{8'h08, 8'h08, 8'h08, 8'h06, 8'h08, 8'h08, 8'h08, 8'h88};
	int code [8] = '{0, 1, 2, 3, 4, 5, 6, 1};
	int per [8] = '{10, 8, 2, 3, 16, 2, 4, 40};
	int n_fail = 0;
	int checks = 0;
	int seed = 86;
	int p;
	always #2 clk_sys = ~clk_sys;
	pdc_top pdc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .vco_tick(vco_tick),
		.ref_tick(ref_tick), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pll_cfg(pll_cfg), .first_output_pin(first_output_pin),
		.second_output_pin_o(second_output_pin_o), .second_output_pin_oe(second_output_pin_oe));
	pdc_tick_src pdc_tick_src_inst (.clk_sys(clk_sys), .vco_tick(vco_tick), .ref_tick(ref_tick));
	////////////////////////////////////////
	function automatic logic [7:0] keep(input logic [7:0] ad, input logic [7:0] dt);
		case (ad)
			8'h09: return dt & 8'h18;
			8'h40: return {3'h6, dt[4:0]};
			8'h45: return dt | 8'h81;
			8'h0C, 8'h41, 8'h42, 8'h47: return dt;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [31:0] exp_cfg();
		logic [11:0] m;
		m = (({2'h0, sh[8'h40][1:0], sh[8'h41]} + 12'h004) << 1) + {11'h000, sh[8'h42][7]};
		return {9'h000, m, {1'b0, sh[8'h42][6:0]} + 8'h02, sh[8'h40][4:2]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b1;
		reg_addr = ad;
		reg_wdata = dt;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		sh[ad] = keep(ad, dt);
	endtask
	task automatic rd(input logic [7:0] ad);
		@(posedge clk_sys);
		#1;
		reg_addr = ad;
		@(posedge clk_sys);
		#1;
		chk(32'(reg_rdata), 32'(sh[ad]));
	endtask
	task automatic meas(input bit s, output int pr);
		int k;
		logic q0, q1;
		k = 0;
		pr = 0;
		q0 = 1'b1;
		for (int i = 0; i < 600 && k < 2; i++) begin
			@(posedge clk_sys);
			#1;
			q1 = s ? second_output_pin_o : first_output_pin;
			k += (q1 && !q0);
			pr += (k == 1);
			q0 = q1;
		end
	endtask
	task automatic align(input logic [7:0] src);
		int bad;
		logic f0, s0;
		bad = 0;
		f0 = 1'b1;
		s0 = 1'b1;
		wr(8'h45, src);
		repeat (200) @(posedge clk_sys);
		repeat (300) begin
			@(posedge clk_sys);
			#1;
			bad += (first_output_pin && !f0 && !(second_output_pin_o && !s0));
			f0 = first_output_pin;
			s0 = second_output_pin_o;
		end
		chk(bad, 0);
	endtask
	task automatic wrap_up();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		foreach (sh[i]) sh[i] = keep(8'(i), 8'h00);
		sh[8'h09] = 8'h08;
		sh[8'h0C] = 8'h08;
		sh[8'h47] = 8'h08;
		sh[8'h45] = 8'h8F;
		repeat (5) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		foreach (adr[i]) rd(adr[i]);
		chk(32'(pll_cfg), exp_cfg());
		wr(8'h40, 8'hE3);
		wr(8'h41, 8'hFF);
		wr(8'h42, 8'hFF);
		rd(8'h40);
		chk(32'(pll_cfg.total_mult), 32'd2055);
		chk(32'(pll_cfg.total_prediv), 32'd129);
		wr(8'h42, 8'h05);
		wr(8'h41, 8'hC8);
		wr(8'h40, 8'hC4);
		rd(8'h40);
		chk(32'(pll_cfg.total_mult), 32'd408);
		chk(32'(pll_cfg.pump_code), 32'd1);
		repeat (40) begin
			a = adr[$unsigned($random(seed)) % 7];
			d = 8'($random(seed));
			if (a == 8'h40 && d[4]) d[3:2] = 2'h0;
			if ((a == 8'h0C || a == 8'h47) && d[6:0] < 7'h04) d[2] = 1'b1;
			if (a == 8'h45 && d[6:4] == 3'h7) d[6] = 1'b0;
			wr(a, d);
			rd(a);
			chk(32'(pll_cfg), exp_cfg());
		end
		wr(8'h09, 8'h18);
		wr(8'h47, 8'h10);
		foreach (code[i]) begin
			wr(8'h0C, b1[i]);
			wr(8'h45, 8'(8'h81 | (code[i] << 4) | (code[i] << 1)));
			repeat (200) @(posedge clk_sys);
			meas(1'b0, p);
			chk(p, per[i]);
			meas(1'b1, p);
			chk(p, per[i]);
		end
		wr(8'h0C, 8'h08);
		align(8'h95);
		align(8'hCD);
		align(8'hCB);
		wr(8'h0C, 8'h06);
		align(8'h97);
		wr(8'h45, 8'h8F);
		wr(8'h09, 8'h00);
		repeat (400) @(posedge clk_sys);
		#1;
		chk(32'(first_output_pin), 32'h0);
		chk(32'(second_output_pin_oe), 32'h0);
		wr(8'h09, 8'h18);
		repeat (1100) @(posedge clk_sys);
		#1;
		chk(32'(second_output_pin_oe), 32'h0);
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end
endmodule // pdc_top_tb
